// *** bit0_mux_pkg.sv ***
// shared constants and types for the channel 1 transmit bit 0 pin mux
package bit0_mux_pkg;

  // -------------------------------------------------------------------------
  // widths and reset values
  // -------------------------------------------------------------------------
  localparam int        BYTE_W       = 8;
  localparam int        UPPER_LSB    = 1;
  localparam int        CNT_W        = 8;
  localparam logic [7:0] BYTE_RST    = 8'h00;

  // -------------------------------------------------------------------------
  // byte clock timing: ref clock cycles per half period of the byte clock
  // -------------------------------------------------------------------------
  localparam int        HDLC_HALF_DIV_DEF = 2;

  // -------------------------------------------------------------------------
  // configured operating mode of the device
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MAPPER,
    MODE_HDLC,
    MODE_ATM
  } op_mode_t;

  // -------------------------------------------------------------------------
  // role currently served by the shared pin
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ROLE_NONE,
    ROLE_ADD_BUS,
    ROLE_HDLC,
    ROLE_GFC
  } role_t;

endpackage : bit0_mux_pkg

// *** bit_sync.sv ***
// two-flop synchroniser, selectable edge, one flop pair per bit
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH    = 1,
  parameter bit NEG_EDGE = 1'b0
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // the first stage is read only by the second stage
  generate
    if (NEG_EDGE) begin : g_neg
      always_ff @(negedge clk_in) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
      end
    end else begin : g_pos
      always_ff @(posedge clk_in) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
      end
    end
  endgenerate

endmodule : bit_sync

`default_nettype wire

// *** tx_ch1_input_bit0_mux.sv ***
// channel 1 transmit bit 0 pin: add bus, byte-wide frame input, flow msb
`timescale 1ns/1ps
`default_nettype none

module tx_ch1_input_bit0_mux
  import bit0_mux_pkg::*;
#(
  parameter int HDLC_HALF_DIV = bit0_mux_pkg::HDLC_HALF_DIV_DEF
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  add_bus_ch1_clock_in,
  input  wire logic                  add_bus_enable_in,
  input  wire bit0_mux_pkg::op_mode_t op_mode_in,
  input  wire logic                  add_bus_ch1_bit0_in,
  output var  logic                  add_bus_ch1_bit0_out,
  output var  logic                  add_bus_ch1_bit0_oe_out,
  input  wire logic [7:1]            add_bus_ch1_upper_bits_in,
  output var  logic [7:0]            add_bus_byte_out,
  output var  logic                  add_bus_valid_out,
  output var  logic                  tx_frame_ctrl_ch1_byte_clock_out,
  output var  logic [7:0]            tx_frame_ctrl_ch1_data_bus_out,
  output var  logic                  tx_frame_ctrl_ch1_valid_out,
  output var  logic                  tx_flow_field_msb_ch1_out,
  output var  bit0_mux_pkg::role_t   role_out
);

  import bit0_mux_pkg::*;

  // -------------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------------
  generate
    if (HDLC_HALF_DIV < 1 || HDLC_HALF_DIV > (1 << CNT_W)) begin : g_bad_div
      $error("HDLC_HALF_DIV out of range");
    end
  endgenerate

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  role_t              role_reg;
  role_t              role_next;
  logic [BYTE_W-1:0]  pin_sync;
  logic               req_sync;
  logic               link_rst_sync;
  logic               link_en_sync;
  logic               ack_sync;
  logic               req_reg;
  logic [BYTE_W-1:0]  hold_reg;
  logic               ack_reg;
  logic [CNT_W-1:0]   div_cnt_reg;
  logic               hclk_reg;
  logic               hclk_prev_reg;
  logic               hclk_rise;
  localparam int      LEN_W = CNT_W + 1;
  logic [LEN_W-1:0]   high_len_reg;

  // -------------------------------------------------------------------------
  // crossings
  // -------------------------------------------------------------------------
  // pins and the link request into the reference domain
  bit_sync #(
    .WIDTH    (BYTE_W + 1),
    .NEG_EDGE (1'b0)
  ) u_ref_sync (
    .clk_in   (ref_clk_in),
    .async_in ({req_reg, add_bus_ch1_upper_bits_in, add_bus_ch1_bit0_in}),
    .sync_out ({req_sync, pin_sync})
  );

  // reset, enable and acknowledge into the link domain, on its capture edge
  bit_sync #(
    .WIDTH    (3),
    .NEG_EDGE (1'b1)
  ) u_link_sync (
    .clk_in   (add_bus_ch1_clock_in),
    .async_in ({reset_in, add_bus_enable_in, ack_reg}),
    .sync_out ({link_rst_sync, link_en_sync, ack_sync})
  );

  // -------------------------------------------------------------------------
  // role selection
  // -------------------------------------------------------------------------
  always_comb begin
    role_next = ROLE_NONE;
    if (add_bus_enable_in) begin
      role_next = ROLE_ADD_BUS;
    end else begin
      case (op_mode_in)
        MODE_HDLC: role_next = ROLE_HDLC;
        MODE_ATM:  role_next = ROLE_GFC;
        default:   role_next = ROLE_NONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      role_reg <= ROLE_NONE;
    end else begin
      role_reg <= role_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      role_out <= ROLE_NONE;
    end else begin
      role_out <= role_next;
    end
  end

  // the pin is an input in every role served here, so it is never driven
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      add_bus_ch1_bit0_out    <= 1'b0;
      add_bus_ch1_bit0_oe_out <= 1'b0;
    end else begin
      add_bus_ch1_bit0_out    <= 1'b0;
      add_bus_ch1_bit0_oe_out <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // add bus capture, link domain
  // -------------------------------------------------------------------------
  // one byte is held until the reference side acknowledges it; bytes that
  // arrive meanwhile are dropped, the trade for having no buffer here
  always_ff @(negedge add_bus_ch1_clock_in) begin
    if (link_rst_sync) begin
      req_reg  <= 1'b0;
      hold_reg <= BYTE_RST;
    end else if (link_en_sync && (req_reg == ack_sync)) begin
      hold_reg <= {add_bus_ch1_upper_bits_in, add_bus_ch1_bit0_in};
      req_reg  <= ~req_reg;
    end
  end

  // -------------------------------------------------------------------------
  // add bus hand-over, reference domain
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req_sync;
    end
  end

  // hold_reg is stable while the request and acknowledge differ
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      add_bus_byte_out  <= BYTE_RST;
      add_bus_valid_out <= 1'b0;
    end else begin
      add_bus_valid_out <= 1'b0;
      if ((req_sync != ack_reg) && (role_reg == ROLE_ADD_BUS)) begin
        add_bus_byte_out  <= hold_reg;
        add_bus_valid_out <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // byte clock generation
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || role_reg != ROLE_HDLC) begin
      div_cnt_reg <= '0;
      hclk_reg    <= 1'b0;
    end else if (div_cnt_reg == CNT_W'(HDLC_HALF_DIV - 1)) begin
      div_cnt_reg <= '0;
      hclk_reg    <= ~hclk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      hclk_prev_reg <= 1'b0;
    end else begin
      hclk_prev_reg <= hclk_reg;
    end
  end

  // length of the current high phase, kept only for the check below
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !hclk_reg) begin
      high_len_reg <= '0;
    end else begin
      high_len_reg <= high_len_reg + LEN_W'(1);
    end
  end

  assign tx_frame_ctrl_ch1_byte_clock_out = hclk_reg;
  assign hclk_rise = hclk_reg && !hclk_prev_reg;

  // -------------------------------------------------------------------------
  // byte-wide frame input capture
  // -------------------------------------------------------------------------
  // the pins pass the synchroniser first, so the byte taken is the one
  // that stood about two reference cycles before the rising edge
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      tx_frame_ctrl_ch1_data_bus_out <= BYTE_RST;
      tx_frame_ctrl_ch1_valid_out    <= 1'b0;
    end else begin
      tx_frame_ctrl_ch1_valid_out <= 1'b0;
      if (hclk_rise && role_reg == ROLE_HDLC) begin
        tx_frame_ctrl_ch1_data_bus_out <= pin_sync;
        tx_frame_ctrl_ch1_valid_out    <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // flow field msb indicator
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      tx_flow_field_msb_ch1_out <= 1'b0;
    end else begin
      tx_flow_field_msb_ch1_out <= (role_reg == ROLE_GFC)
                                   && pin_sync[0];
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  a_role_add_first: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    add_bus_enable_in |=> (role_reg == ROLE_ADD_BUS)
  ) else $error("add bus enable did not select the add bus role");

  a_role_frame_mode: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (!add_bus_enable_in && op_mode_in == MODE_HDLC)
      |=> (role_reg == ROLE_HDLC)
  ) else $error("frame mode did not select the frame input role");

  a_add_byte_role: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    add_bus_valid_out |-> ($past(role_reg) == ROLE_ADD_BUS)
      ##1 !add_bus_valid_out
  ) else $error("add bus byte outside add bus role or not a pulse");

  a_link_hold_stable: assert property (
    @(negedge add_bus_ch1_clock_in) disable iff (link_rst_sync)
    (req_reg != ack_sync) |=> $stable(hold_reg)
  ) else $error("held add bus byte changed before acknowledge");

  a_byte_clock_high: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ($fell(hclk_reg) && ($past(role_reg) == ROLE_HDLC))
      |-> (high_len_reg == LEN_W'(HDLC_HALF_DIV))
  ) else $error("byte clock high phase has the wrong length");

  a_byte_clock_idle: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (role_reg != ROLE_HDLC) |=> !tx_frame_ctrl_ch1_byte_clock_out
  ) else $error("byte clock runs outside frame mode");

  a_frame_rise_sample: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    tx_frame_ctrl_ch1_valid_out |-> $past(hclk_reg) && !$past(hclk_reg, 2)
  ) else $error("frame byte not taken at the byte clock rising edge");

  a_flow_msb_gate: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (role_reg != ROLE_GFC) |=> !tx_flow_field_msb_ch1_out
  ) else $error("flow msb indicator active outside atm mode");

  a_none_ignored: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (role_reg == ROLE_NONE) |=> (!add_bus_valid_out
      && !tx_frame_ctrl_ch1_valid_out && !tx_flow_field_msb_ch1_out)
  ) else $error("pin value had an effect with no role selected");

  a_pin_never_driven: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !add_bus_ch1_bit0_oe_out
  ) else $error("input pin output enable asserted");

  a_role_atm_mode: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (!add_bus_enable_in && op_mode_in == MODE_ATM)
      |=> (role_reg == ROLE_GFC)
  ) else $error("atm mode did not select the flow msb role");

  a_role_no_match: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (!add_bus_enable_in && op_mode_in != MODE_HDLC && op_mode_in != MODE_ATM)
      |=> (role_reg == ROLE_NONE)
  ) else $error("a role was selected where none applies");

  a_link_gate_off: assert property (
    @(negedge add_bus_ch1_clock_in) disable iff (link_rst_sync)
    !link_en_sync |=> $stable(req_reg)
  ) else $error("add bus byte taken while the add bus is disabled");

endmodule : tx_ch1_input_bit0_mux

`default_nettype wire

// *** equipment_model.sv ***
// far-side terminal equipment model driving the channel 1 input pins
`timescale 1ns/1ps
`default_nettype none

module equipment_model (
  input  wire logic       ref_clk_in,
  input  wire logic       link_run_in,
  input  wire logic       hdlc_mode_in,
  input  wire logic       byte_clock_in,
  input  wire logic       gfc_in,
  input  wire logic [7:0] add_byte_in,
  input  wire logic [7:0] hdlc_next_in,
  input  wire logic [7:0] noise_in,
  output var  logic       link_clk_out,
  output var  logic [7:0] pins_out,
  output var  logic [7:0] hdlc_prev_out
);
  logic [7:0] add_reg;
  logic [7:0] cur_reg = 8'h00;
  logic       bc_reg = 1'b0;

  // link clock stands low while no traffic is offered
  initial begin
    link_clk_out = 1'b0;
    #1.3;
    forever #3 link_clk_out = link_run_in ? ~link_clk_out : 1'b0;
  end

  // byte moves on the rising link edge so it is steady at the fall
  always_ff @(posedge link_clk_out) add_reg <= add_byte_in;

  // next byte is offered right after each byte clock rise
  always_ff @(posedge ref_clk_in) begin
    bc_reg <= byte_clock_in;
    if (byte_clock_in && !bc_reg) begin
      hdlc_prev_out <= cur_reg;
      cur_reg       <= hdlc_next_in;
    end
  end

  // released pins show changing noise on bits 7:1 and gfc_in on bit 0, never the last byte
  always_comb begin
    if (hdlc_mode_in) pins_out = cur_reg;
    else if (link_run_in) pins_out = add_reg;
    else pins_out = {noise_in[7:1], gfc_in};
  end
endmodule : equipment_model
`default_nettype wire

// *** test_tx_ch1_input_bit0_mux.sv ***
// self-checking bench for the channel 1 transmit bit 0 pin mux
`timescale 1ns/1ps
`default_nettype none

module test_tx_ch1_input_bit0_mux;
  import bit0_mux_pkg::*;
  logic       clk, rst, en, run, hm, gfc, lclk, oe, pout, av, bclk, tv;
  logic       flow, lb;
  op_mode_t   mode;
  role_t      role;
  logic [7:0] abyte, nxt, noise, pins, prev, ab, td;
  int         seed = 51035;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         i, n;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    nxt   <= 8'($random(seed));
    noise <= 8'($random(seed));
  end

  equipment_model equipment_model_i (.ref_clk_in(clk), .link_run_in(run),
    .hdlc_mode_in(hm), .byte_clock_in(bclk), .gfc_in(gfc),
    .add_byte_in(abyte), .hdlc_next_in(nxt), .noise_in(noise),
    .link_clk_out(lclk), .pins_out(pins), .hdlc_prev_out(prev));

  tx_ch1_input_bit0_mux #(.HDLC_HALF_DIV(2)) tx_ch1_input_bit0_mux_i (
    .ref_clk_in(clk), .reset_in(rst), .add_bus_ch1_clock_in(lclk),
    .add_bus_enable_in(en), .op_mode_in(mode),
    .add_bus_ch1_bit0_in(pins[0]), .add_bus_ch1_bit0_out(pout),
    .add_bus_ch1_bit0_oe_out(oe), .add_bus_ch1_upper_bits_in(pins[7:1]),
    .add_bus_byte_out(ab), .add_bus_valid_out(av),
    .tx_frame_ctrl_ch1_byte_clock_out(bclk),
    .tx_frame_ctrl_ch1_data_bus_out(td), .tx_frame_ctrl_ch1_valid_out(tv),
    .tx_flow_field_msb_ch1_out(flow), .role_out(role));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic role_t exp_role(input logic e, input op_mode_t m);
    if (e) return ROLE_ADD_BUS;
    if (m == MODE_HDLC) return ROLE_HDLC;
    if (m == MODE_ATM) return ROLE_GFC;
    return ROLE_NONE;
  endfunction : exp_role

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : cmp

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic setcfg(input logic e, input op_mode_t m, input logic r,
                        input logic h);
    @(posedge clk);
    en   <= e;
    mode <= m;
    run  <= r;
    hm   <= h;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : setcfg

  // bounded wait for a one-cycle pulse, seen at the falling edge
  task automatic wait_pulse(input logic sel);
    for (int k = 0; k < 60; k++) begin
      @(negedge clk);
      if ((sel ? tv : av) === 1'b1) return;
    end
    $display("MISMATCH pulse expected 1 seen 0");
    bad_count++;
    summarize();
  endtask : wait_pulse

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    en = 1'b0;
    mode = MODE_MAPPER;
    run = 1'b1;
    hm = 1'b0;
    gfc = 1'b0;
    abyte = 8'h00;
    nxt = 8'h00;
    noise = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      setcfg(i[2], op_mode_t'(i[1:0]), 1'b0, 1'b0);
      cmp("role", 8'(exp_role(i[2], op_mode_t'(i[1:0]))), 8'(role));
      cmp("pin drive", 8'h00, {6'h00, oe, pout});
    end
    setcfg(1'b0, MODE_MAPPER, 1'b0, 1'b0);
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      gfc <= 1'($random(seed));
      @(negedge clk);
      cmp("idle outputs", 8'h00, {4'h0, av, bclk, tv, flow});
    end
    setcfg(1'b0, MODE_ATM, 1'b0, 1'b0);
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      gfc <= 1'($random(seed));
      repeat (5) @(posedge clk);
      @(negedge clk);
      cmp("flow msb", {7'h00, gfc}, {7'h00, flow});
    end
    setcfg(1'b0, MODE_HDLC, 1'b0, 1'b1);
    n = 0;
    lb = bclk;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (bclk && !lb) n++;
      lb = bclk;
    end
    cmp("byte clock rises", 8'h0A, 8'(n));
    wait_pulse(1'b1);
    for (i = 0; i < 10; i++) begin
      wait_pulse(1'b1);
      cmp("frame byte", prev, td);
    end
    // reset in mid-run: every output falls back to its idle value
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp("reset role", 8'h00, 8'(role));
    cmp("reset flags", 8'h00, {2'h0, av, bclk, tv, flow, oe, pout});
    cmp("reset bytes", 8'h00, td | ab);
    @(posedge clk);
    rst <= 1'b0;
    setcfg(1'b1, MODE_MAPPER, 1'b1, 1'b0);
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      abyte <= (i == 0) ? 8'h01 : (i == 1) ? 8'hFE : 8'($random(seed));
      repeat (20) @(posedge clk);
      wait_pulse(1'b0);
      cmp("add byte", abyte, ab);
    end
    summarize();
  end
endmodule : test_tx_ch1_input_bit0_mux
`default_nettype wire
